// ==== halting_debug_pkg.sv ====
package halting_debug_pkg;
  // ==========================================================
  // Register map
  localparam logic [31:0] EVT_STATUS_ADDR = 32'hE000ED30;
  localparam logic [31:0] HALT_CTL_ADDR = 32'hE000EDF0;
  localparam logic [31:0] EVT_STATUS_ALIAS_ADDR = 32'hE002ED30;
  localparam logic [31:0] HALT_CTL_ALIAS_ADDR = 32'hE002EDF0;
  localparam logic [15:0] WRITE_KEY = 16'hA05F;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // ==========================================================
  // Event status fields
  localparam int EVT_W = 5;
  localparam int EVT_EXTERNAL = 4;
  localparam int EVT_VECTOR = 3;
  localparam int EVT_WATCH = 2;
  localparam int EVT_BREAK = 1;
  localparam int EVT_HALTSTEP = 0;
  // ==========================================================
  // Halt control and status fields
  localparam int KEY_LSB = 16;
  localparam int KEY_MSB = 31;
  localparam int RESTART_ST_BIT = 26;
  localparam int RESET_ST_BIT = 25;
  localparam int RETIRE_ST_BIT = 24;
  localparam int SDE_BIT = 20;
  localparam int LOCKUP_BIT = 19;
  localparam int SLEEP_BIT = 18;
  localparam int HALTED_BIT = 17;
  localparam int XFER_DONE_BIT = 16;
  localparam int SNAP_BIT = 5;
  localparam int MASK_BIT = 3;
  localparam int STEP_BIT = 2;
  localparam int HALT_BIT = 1;
  localparam int DBGEN_BIT = 0;
  // ==========================================================
  // Build options
  localparam logic HALT_DEBUG_PRESENT = 1'b1;
  localparam logic WATCH_UNIT_PRESENT = 1'b1;
endpackage : halting_debug_pkg

// ==== pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_t;

  sync_t state_ff;
  sync_t nxt_state;

  // A change is taken only once the second and third stages agree.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.s1 = pin;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    if (state_ff.s2 == state_ff.s3) begin
      nxt_state.q = state_ff.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign level = state_ff.q;
endmodule : pin_sync

// ==== halting_debug_ctl.sv ====
`timescale 1ns/1ps
// How it works
// - Event status holds 5 flags in bits 4 to 0; writing one clears a flag, zero keeps it.
// - Only privileged accesses reach the registers; others give a bus fault.
// - External request event sets bit 4, sticky, cleared by cold reset.
// - Vector trap event sets bit 3, sticky; zero without halting debug.
// - Watchpoint event sets bit 2, sticky; zero without the watch unit.
// - Breakpoint event sets bit 1, sticky, cleared by cold reset.
// - Halt or step event sets bit 0, sticky, cleared by cold reset.
// - Control writes land only with the key in the upper half.
// - Clearing the halt request sets restart sticky bit 26; reads clear it.
// - Simultaneous clear and set of halt: leave, re-enter, set restart sticky.
// - Reset sticky bit 25 is one after any reset; reads clear it.
// - Retire sticky bit 24 sets on retirement; reads clear it.
// - Secure-debug bit follows permission outside debug, frozen inside.
// - Lockup bit reads one only to the debugger; clears on debug entry.
// - Bit 18 shows sleep, bit 17 shows Debug state.
// - Transfer-done bit 16 is zero while a core register transfer runs.
// - Imprecise entry works only with enable and halt; blocked without secure debug.
// - Interrupt mask hides low-priority interrupts, not secure ones without secure debug.
// - Step acts as zero when disabled or secure-prohibited in Secure state.
// - Halt request halts; clearing it leaves; events in bits 4 to 1 set it while debug is enabled; warm reset clears.
// - Debug enable is debugger-only, cold-reset zero, gates mask, step, halt.
module halting_debug_ctl
  import halting_debug_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic warm_reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [1:0] req_size,
  input wire logic req_priv,
  input wire logic req_secure,
  input wire logic req_from_debugger,
  output logic rsp_valid,
  output logic rsp_fault,
  output logic [31:0] rsp_rdata,
  input wire logic external_request_pin,
  input wire logic external_restart_pin,
  input wire logic vector_trap_event,
  input wire logic watchpoint_event,
  input wire logic breakpoint_event,
  input wire logic halt_step_event,
  input wire logic halt_allowed,
  input wire logic secure_halt_allowed,
  input wire logic core_secure_state,
  input wire logic core_sleeping,
  input wire logic core_locked_up,
  input wire logic instr_retired,
  input wire logic xfer_start,
  input wire logic xfer_complete,
  output logic core_halted,
  output logic halt_request,
  output logic step_enable,
  output logic mask_ints,
  output logic mask_secure_ints,
  output logic imprecise_entry,
  output logic reentry_pulse
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [EVT_W-1:0] evt;
    logic halt;
    logic step;
    logic mask;
    logic snap;
    logic dbgen;
    logic restart_st;
    logic reset_st;
    logic retire_st;
    logic sde;
    logic in_dbg;
    logic xfer_done;
    logic o_halt;
    logic o_step;
    logic o_mask;
    logic o_mask_s;
    logic o_snap;
    logic reentry;
    logic rsp_valid;
    logic rsp_fault;
    logic [31:0] rsp_rdata;
  } ctl_t;

  ctl_t state_ff;
  ctl_t nxt_state;
  logic ext_req;
  logic ext_restart;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
    hit = (a == base);
  endfunction : hit

  function automatic logic halt_gate(input logic en, input logic sde, input logic sec);
    halt_gate = en & ~(~sde & sec);
  endfunction : halt_gate

  pin_sync u_req_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin(external_request_pin),
    .level(ext_req)
  );

  pin_sync u_restart_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin(external_restart_pin),
    .level(ext_restart)
  );

  // ==========================================================
  // Next state
  logic acc_ok;
  logic alias_ok;
  logic sel_evt;
  logic sel_hcs;
  logic wr_word;
  logic key_ok;
  logic nxt_en;
  logic halt_clr;
  logic halt_set;
  logic [EVT_W-1:0] ev;
  logic [EVT_W-1:0] clr;
  logic [31:0] hcs_rd;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rsp_valid = req_valid;
    nxt_state.rsp_fault = 1'b0;
    nxt_state.rsp_rdata = '0;
    nxt_state.reentry = 1'b0;
    acc_ok = req_valid & req_priv;
    // Aliases exist only for Secure software; others see zeros.
    alias_ok = ~req_from_debugger & req_secure;
    sel_evt = acc_ok & (hit(req_addr, EVT_STATUS_ADDR) |
      (hit(req_addr, EVT_STATUS_ALIAS_ADDR) & alias_ok));
    sel_hcs = acc_ok & (hit(req_addr, HALT_CTL_ADDR) |
      (hit(req_addr, HALT_CTL_ALIAS_ADDR) & alias_ok));
    wr_word = req_write & (req_size == SIZE_WORD);
    key_ok = sel_hcs & wr_word & (req_wdata[KEY_MSB:KEY_LSB] == WRITE_KEY);

    ev = '0;
    ev[EVT_EXTERNAL] = ext_req;
    ev[EVT_VECTOR] = vector_trap_event & HALT_DEBUG_PRESENT;
    ev[EVT_WATCH] = watchpoint_event & WATCH_UNIT_PRESENT;
    ev[EVT_BREAK] = breakpoint_event;
    ev[EVT_HALTSTEP] = halt_step_event;
    // write one to clear, set wins
    clr = (sel_evt & wr_word) ? req_wdata[EVT_W-1:0] : '0;
    nxt_state.evt = (state_ff.evt & ~clr) | ev;

    // read clears the sticky bits before new sets
    if (sel_hcs & ~req_write) begin
      nxt_state.restart_st = 1'b0;
      nxt_state.reset_st = 1'b0;
      nxt_state.retire_st = 1'b0;
    end

    halt_clr = 1'b0;
    if (key_ok) begin
      if (req_from_debugger) begin
        nxt_state.dbgen = req_wdata[DBGEN_BIT];
      end
      nxt_state.halt = req_wdata[HALT_BIT];
      nxt_state.step = req_wdata[STEP_BIT];
      nxt_state.mask = req_wdata[MASK_BIT];
      // ignored while secure debug is prohibited
      if (state_ff.sde) begin
        nxt_state.snap = req_wdata[SNAP_BIT];
      end
      halt_clr = state_ff.halt & ~req_wdata[HALT_BIT];
    end
    // external restart clears the halt request
    if (ext_restart & state_ff.halt) begin
      nxt_state.halt = 1'b0;
      halt_clr = 1'b1;
    end
    halt_set = state_ff.dbgen & (|ev[EVT_W-1:EVT_BREAK]);
    if (halt_set) begin
      nxt_state.halt = 1'b1;
    end
    if (halt_clr) begin
      nxt_state.restart_st = 1'b1;
    end
    nxt_state.reentry = halt_clr & halt_set & state_ff.in_dbg;
    if (instr_retired) begin
      nxt_state.retire_st = 1'b1;
    end
    if (xfer_start) begin
      nxt_state.xfer_done = 1'b0;
    end else if (xfer_complete) begin
      nxt_state.xfer_done = 1'b1;
    end
    // warm reset drops the halt request
    if (warm_reset) begin
      nxt_state.halt = 1'b0;
      nxt_state.reset_st = 1'b1;
    end

    // Debug state tracks the effective halt request
    nxt_en = nxt_state.dbgen & halt_allowed;
    nxt_state.in_dbg = nxt_state.halt &
      halt_gate(nxt_en, state_ff.sde, core_secure_state);
    // follow outside, capture on entry, hold inside
    if (!state_ff.in_dbg) begin
      nxt_state.sde = nxt_state.in_dbg ? (secure_halt_allowed | core_secure_state)
                                       : secure_halt_allowed;
    end

    // controls act as zero while disabled
    nxt_state.o_halt = nxt_state.halt & nxt_en;
    nxt_state.o_step = nxt_state.step &
      halt_gate(nxt_en, nxt_state.sde, core_secure_state);
    // mask, secure targets spared without secure debug
    nxt_state.o_mask = nxt_state.mask & nxt_en;
    nxt_state.o_mask_s = nxt_state.mask & nxt_en & nxt_state.sde;
    // imprecise entry only alongside enable and halt
    nxt_state.o_snap = nxt_state.snap & nxt_en & nxt_state.halt;

    hcs_rd = '0;
    hcs_rd[RESTART_ST_BIT] = state_ff.restart_st;
    hcs_rd[RESET_ST_BIT] = state_ff.reset_st;
    hcs_rd[RETIRE_ST_BIT] = state_ff.retire_st;
    hcs_rd[SDE_BIT] = state_ff.sde;
    // lockup seen by the debugger only
    hcs_rd[LOCKUP_BIT] = req_from_debugger & core_locked_up & ~state_ff.in_dbg;
    hcs_rd[SLEEP_BIT] = core_sleeping;
    hcs_rd[HALTED_BIT] = state_ff.in_dbg;
    hcs_rd[XFER_DONE_BIT] = state_ff.xfer_done;
    hcs_rd[SNAP_BIT] = state_ff.snap;
    hcs_rd[MASK_BIT] = state_ff.mask;
    hcs_rd[STEP_BIT] = state_ff.step;
    hcs_rd[HALT_BIT] = state_ff.halt;
    hcs_rd[DBGEN_BIT] = state_ff.dbgen;

    // unprivileged access faults and reads zero
    if (req_valid & ~req_priv) begin
      nxt_state.rsp_fault = 1'b1;
    end else if (sel_evt & ~req_write) begin
      nxt_state.rsp_rdata = {{(32 - EVT_W){1'b0}}, state_ff.evt};
    end else if (sel_hcs & ~req_write) begin
      nxt_state.rsp_rdata = hcs_rd;
    end
  end

  // A cold reset clears everything except reset sticky and transfer done, which start at one.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
      state_ff.reset_st <= 1'b1;
      state_ff.xfer_done <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rsp_valid = state_ff.rsp_valid;
  assign rsp_fault = state_ff.rsp_fault;
  assign rsp_rdata = state_ff.rsp_rdata;
  assign core_halted = state_ff.in_dbg;
  assign halt_request = state_ff.o_halt;
  assign step_enable = state_ff.o_step;
  assign mask_ints = state_ff.o_mask;
  assign mask_secure_ints = state_ff.o_mask_s;
  assign imprecise_entry = state_ff.o_snap;
  assign reentry_pulse = state_ff.reentry;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence ext_event_s;
    ext_req && !(sel_evt && wr_word && req_wdata[EVT_EXTERNAL]);
  endsequence

  sequence restart_s;
    ext_restart && state_ff.halt && !halt_set && !(sel_hcs && !req_write);
  endsequence

  ext_flag_a: assert property (ext_event_s |=> state_ff.evt[EVT_EXTERNAL])
    else $error("external flag not set");
  w1c_clear_a: assert property (sel_evt && wr_word && req_wdata[EVT_BREAK] && !breakpoint_event
    |=> !state_ff.evt[EVT_BREAK])
    else $error("breakpoint flag not cleared");
  priv_fault_a: assert property (req_valid && !req_priv
    |=> rsp_fault && rsp_valid && rsp_rdata == '0)
    else $error("unprivileged access not faulted");
  key_guard_a: assert property (sel_hcs && wr_word && req_wdata[KEY_MSB:KEY_LSB] != WRITE_KEY
    |=> $stable(state_ff.step) && $stable(state_ff.mask))
    else $error("unkeyed write changed control");
  restart_set_a: assert property (restart_s |=> state_ff.restart_st ##1 !state_ff.in_dbg)
    else $error("restart not recorded");
  warm_sticky_a: assert property (warm_reset |=> state_ff.reset_st && !state_ff.halt)
    else $error("warm reset effects missing");
  sde_hold_a: assert property (state_ff.in_dbg && $past(state_ff.in_dbg)
    |-> $stable(state_ff.sde))
    else $error("secure debug bit moved in debug");
  step_gate_a: assert property (!state_ff.dbgen |-> !step_enable && !mask_ints)
    else $error("controls active while disabled");

  sequence reentry_s;
    halt_clr && halt_set && state_ff.in_dbg;
  endsequence

  reentry_a: assert property (reentry_s
    |=> reentry_pulse && state_ff.restart_st && core_halted)
    else $error("re-entry not flagged");
  retire_set_a: assert property (instr_retired |=> state_ff.retire_st)
    else $error("retire sticky not set");
  xfer_busy_a: assert property (xfer_start |=> !state_ff.xfer_done)
    else $error("transfer done during transfer");
  snap_gate_a: assert property (imprecise_entry |-> halt_request)
    else $error("imprecise entry without halt");
  mask_secure_a: assert property (mask_secure_ints |-> mask_ints && state_ff.sde)
    else $error("secure interrupts masked without secure debug");
endmodule : halting_debug_ctl

// ==== debugger_model.sv ====
`timescale 1ns/1ps
module debugger_model
  import halting_debug_pkg::*;
(
  input wire logic sys_clk,
  output logic req_valid,
  output logic req_write,
  output logic [31:0] req_addr,
  output logic [31:0] req_wdata,
  output logic [1:0] req_size,
  output logic req_priv,
  output logic req_from_debugger,
  input wire logic rsp_valid,
  input wire logic rsp_fault,
  input wire logic [31:0] rsp_rdata
);
  // ==========================================================
  // Idle bus
  initial begin
    {req_valid, req_write, req_priv, req_from_debugger} = 4'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    req_size = SIZE_WORD;
  end

  // ==========================================================
  // One access, answered by the same edge that takes it
  task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic priv, input logic dbg, output logic [31:0] rd,
                        output logic v, output logic f);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_priv <= priv;
    req_from_debugger <= dbg;
    req_size <= SIZE_WORD;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    // Released lines show the inverse so a stale value can never look valid.
    req_addr <= ~a;
    req_wdata <= ~d;
    #1;
    rd = rsp_rdata;
    v = rsp_valid;
    f = rsp_fault;
  endtask : access
endmodule : debugger_model

// ==== halting_debug_ctl_test.sv ====
`timescale 1ns/1ps
module halting_debug_ctl_test;
  import halting_debug_pkg::*;
  logic sys_clk, resetn, warm_reset, external_request_pin, external_restart_pin;
  logic vector_trap_event, watchpoint_event, breakpoint_event, halt_step_event;
  logic halt_allowed, secure_halt_allowed, core_secure_state, core_sleeping, core_locked_up;
  logic instr_retired, xfer_start, xfer_complete, req_valid, req_write, req_priv, req_secure;
  logic req_from_debugger, rsp_valid, rsp_fault, core_halted, halt_request, step_enable;
  logic mask_ints, mask_secure_ints, imprecise_entry, reentry_pulse, v, f;
  logic [31:0] req_addr, req_wdata, rsp_rdata, rd;
  logic [1:0] req_size;
  int err_total, comparisons, cycles;

  halting_debug_ctl DUT (
    .sys_clk, .resetn, .warm_reset, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_size, .req_priv, .req_secure, .req_from_debugger, .rsp_valid, .rsp_fault,
    .rsp_rdata, .external_request_pin, .external_restart_pin, .vector_trap_event,
    .watchpoint_event, .breakpoint_event, .halt_step_event, .halt_allowed,
    .secure_halt_allowed, .core_secure_state, .core_sleeping, .core_locked_up,
    .instr_retired, .xfer_start, .xfer_complete, .core_halted, .halt_request,
    .step_enable, .mask_ints, .mask_secure_ints, .imprecise_entry, .reentry_pulse
  );

  debugger_model u_dbg (
    .sys_clk, .req_valid, .req_write, .req_addr, .req_wdata, .req_size, .req_priv,
    .req_from_debugger, .rsp_valid, .rsp_fault, .rsp_rdata
  );

  // ==========================================================
  // Clock, timeout and helpers
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rd_reg(input logic [31:0] a);
    u_dbg.access(1'b0, a, 32'h0, 1'b1, 1'b1, rd, v, f);
  endtask : rd_reg

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, input logic dbg);
    logic [31:0] r;
    u_dbg.access(1'b1, a, d, 1'b1, dbg, r, v, f);
  endtask : wr_reg

  task automatic hold_pin(input logic restart);
    @(posedge sys_clk);
    if (restart) begin
      external_restart_pin <= 1'b1;
    end else begin
      external_request_pin <= 1'b1;
    end
    repeat (6) @(posedge sys_clk);
    {external_restart_pin, external_request_pin} <= 2'h0;
    repeat (6) @(posedge sys_clk);
  endtask : hold_pin

  // ==========================================================
  // Scenarios
  task automatic test_reset_and_fault();
    rd_reg(HALT_CTL_ADDR);
    chk("reset sticky", 32'h02010000, rd & 32'h02030000);
    rd_reg(HALT_CTL_ADDR);
    chk("sticky cleared", 32'h0, rd & 32'h02000000);
    rd_reg(EVT_STATUS_ADDR);
    chk("flags cold", 32'h0, rd);
    u_dbg.access(1'b0, HALT_CTL_ADDR, 32'h0, 1'b0, 1'b1, rd, v, f);
    chk("fault", 32'h1, {31'h0, v & f});
    chk("fault data", 32'h0, rd);
    u_dbg.access(1'b1, HALT_CTL_ADDR, 32'hA05F0003, 1'b0, 1'b1, rd, v, f);
    chk("fault no write", 32'h0, {31'h0, core_halted});
  endtask : test_reset_and_fault

  task automatic test_key_and_restart();
    wr_reg(HALT_CTL_ADDR, 32'hA05E0003, 1'b1);
    rd_reg(HALT_CTL_ADDR);
    chk("bad key", 32'h0, rd & 32'h00020003);
    wr_reg(HALT_CTL_ADDR, 32'hA05F0003, 1'b1);
    chk("halt request", 32'h1, {31'h0, halt_request});
    chk("halted", 32'h1, {31'h0, core_halted});
    wr_reg(HALT_CTL_ADDR, 32'hA05F0001, 1'b1);
    chk("left debug", 32'h0, {31'h0, core_halted});
    rd_reg(HALT_CTL_ADDR);
    chk("restart sticky", 32'h04000000, rd & 32'h04000000);
    rd_reg(HALT_CTL_ADDR);
    chk("restart cleared", 32'h0, rd & 32'h04000000);
    wr_reg(HALT_CTL_ADDR, 32'hA05F0003, 1'b1);
    hold_pin(1'b1);
    chk("pin restart", 32'h0, {31'h0, core_halted});
    rd_reg(HALT_CTL_ADDR);
    chk("pin sticky", 32'h04000000, rd & 32'h04000000);
  endtask : test_key_and_restart

  task automatic test_events();
    @(posedge sys_clk);
    {vector_trap_event, watchpoint_event, breakpoint_event, halt_step_event} <= 4'hF;
    @(posedge sys_clk);
    {vector_trap_event, watchpoint_event, breakpoint_event, halt_step_event} <= 4'h0;
    rd_reg(EVT_STATUS_ADDR);
    chk("vector flag", 32'h8, rd & 32'h8);
    chk("watch flag", 32'h4, rd & 32'h4);
    chk("break flag", 32'h2, rd & 32'h2);
    chk("step flag", 32'h1, rd & 32'h1);
    hold_pin(1'b0);
    rd_reg(EVT_STATUS_ADDR);
    chk("external flag", 32'h1F, rd);
    wr_reg(EVT_STATUS_ADDR, 32'h2, 1'b1);
    wr_reg(EVT_STATUS_ADDR, 32'h0, 1'b1);
    rd_reg(EVT_STATUS_ADDR);
    chk("clear one", 32'h1D, rd);
    wr_reg(EVT_STATUS_ADDR, 32'h1F, 1'b1);
    rd_reg(EVT_STATUS_ADDR);
    chk("clear all", 32'h0, rd);
    chk("event halts", 32'h1, {31'h0, core_halted});
  endtask : test_events

  task automatic test_status_and_mask();
    @(posedge sys_clk);
    {core_sleeping, core_locked_up, xfer_start, instr_retired} <= 4'hF;
    @(posedge sys_clk);
    {xfer_start, instr_retired} <= 2'h0;
    rd_reg(HALT_CTL_ADDR);
    chk("sleep", 32'h00040000, rd & 32'h00040000);
    chk("xfer busy", 32'h0, rd & 32'h00010000);
    chk("retire", 32'h01000000, rd & 32'h01000000);
    chk("secure allowed", 32'h00100000, rd & 32'h00100000);
    chk("no lockup halted", 32'h0, rd & 32'h00080000);
    @(posedge sys_clk);
    xfer_complete <= 1'b1;
    @(posedge sys_clk);
    xfer_complete <= 1'b0;
    rd_reg(HALT_CTL_ADDR);
    chk("xfer done", 32'h00010000, rd & 32'h01010000);
    wr_reg(HALT_CTL_ADDR, 32'hA05F000B, 1'b1);
    chk("mask", 32'h1, {31'h0, mask_ints});
    chk("mask secure", 32'h1, {31'h0, mask_secure_ints});
    wr_reg(HALT_CTL_ADDR, 32'hA05F0007, 1'b1);
    chk("step", 32'h1, {31'h0, step_enable});
    chk("unmask", 32'h0, {31'h0, mask_ints});
    wr_reg(HALT_CTL_ADDR, 32'hA05F0003, 1'b1);
    // The breakpoint lands on the same edge that takes the halt clear.
    fork
      wr_reg(HALT_CTL_ADDR, 32'hA05F0001, 1'b1);
      begin
        @(posedge sys_clk);
        breakpoint_event <= 1'b1;
        @(posedge sys_clk);
        breakpoint_event <= 1'b0;
      end
    join
    chk("reentry pulse", 32'h1, {31'h0, reentry_pulse});
    chk("reentry halted", 32'h1, {31'h0, core_halted});
    rd_reg(HALT_CTL_ADDR);
    chk("reentry sticky", 32'h04000000, rd & 32'h04000000);
  endtask : test_status_and_mask

  task automatic test_warm_and_imprecise();
    wr_reg(HALT_CTL_ADDR, 32'hA05F0001, 1'b1);
    rd_reg(HALT_CTL_ADDR);
    chk("lockup", 32'h00080000, rd & 32'h00080000);
    wr_reg(HALT_CTL_ADDR, 32'hA05F0023, 1'b1);
    chk("imprecise", 32'h1, {31'h0, imprecise_entry});
    @(posedge sys_clk);
    warm_reset <= 1'b1;
    @(posedge sys_clk);
    warm_reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("warm halt", 32'h0, {31'h0, halt_request});
    rd_reg(HALT_CTL_ADDR);
    chk("warm sticky", 32'h02000000, rd & 32'h02000000);
    wr_reg(HALT_CTL_ADDR, 32'hA05F0000, 1'b0);
    rd_reg(HALT_CTL_ADDR);
    chk("enable kept", 32'h1, rd & 32'h1);
    rd_reg(HALT_CTL_ALIAS_ADDR);
    chk("alias debugger", 32'h0, rd);
    u_dbg.access(1'b0, HALT_CTL_ALIAS_ADDR, 32'h0, 1'b1, 1'b0, rd, v, f);
    chk("alias software", 32'h1, rd & 32'h1);
  endtask : test_warm_and_imprecise

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    {warm_reset, external_request_pin, external_restart_pin, core_secure_state} = 4'h0;
    {vector_trap_event, watchpoint_event, breakpoint_event, halt_step_event} = 4'h0;
    {core_sleeping, core_locked_up, instr_retired, xfer_start, xfer_complete} = 5'h0;
    {halt_allowed, secure_halt_allowed, req_secure} = 3'h7;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    test_reset_and_fault();
    test_key_and_restart();
    test_events();
    test_status_and_mask();
    test_warm_and_imprecise();
    end_of_test();
  end
endmodule : halting_debug_ctl_test
